// [nibble_cpu_datapath.v]
/*
  Execution datapath of a nibble-serial handheld CPU: digit pointer,
  program and hardware flags, keyscan registers, scratch swaps, data
  pointers with nibble-serial memory transfers, shifts, logic and BCD/hex
  arithmetic. Instructions arrive as command words over an Avalon-MM
  slave with waitrequest; memory is a simple req/ack nibble port.
  Assumes one clock, synchronous inputs, and a memory that acks each
  nibble by a one-cycle mem_ack while mem_req_ff is high.
*/
// Implementation choices: the placing of the registers and the Avalon-MM register port.
// Notes on behaviour
// - digit pointer 0..15: load immediate, step up or down with carry
// - add pointer plus one into address field of C
// - swap pointer with nibble n of C, or copy either way
// - flags 0..11 set, clear, clear all, copy or swap with C exponent
// - four hardware flags cleared singly or all together
// - keyscan output from C exponent field or C nibble 0
// - keyscan input into low four nibbles of A or C
// - A or C swap, copy from, copy to any of five scratch registers
// - data pointer swap or load from A/C address field, or low four nibbles
// - data pointer step up or down by 1..16
// - immediate pointer load of 2, 4 or 5 nibbles, overflow dropped
// - memory read/write of selected field at data pointer address
// - right shifts set sticky flag when nonzero bits fall off
// - field shifts by a nibble, circular nibble shifts, bit shift right
// - AND and OR into first register, selected field only
// - negate: ten's or two's complement, carry when value nonzero
// - complement: nine's or one's complement, carry cleared
// - clear, double, increment, decrement, sums, copy, swap on field
// - subtraction only for pairs A-B, B-C, C-A, D-C, either order
// - idle instructions change nothing in the datapath
// - hex or decimal mode chosen by command, steers nibble arithmetic
// - interrupt disable masks only ordinary interrupts
// - sixteen-nibble registers with nine documented field selects
// - address field covers nibbles 0..4
`timescale 1ns/1ns
`include "nibble_cpu_defs.vh"

module nibble_cpu_datapath (
  // clock, reset, enable
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        clk_en,
  // avalon-mm slave
  input  wire [6:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // system memory port
  output reg         mem_req_ff,
  output reg         mem_we_ff,
  output reg  [19:0] mem_addr_ff,
  output reg  [3:0]  mem_wdata_ff,
  input  wire [3:0]  mem_rdata,
  input  wire        mem_ack,
  // keyscan
  input  wire [15:0] keyscan_in,
  output reg  [11:0] keyscan_out_ff,
  // hardware events and interrupts
  input  wire        sreq_event,
  input  wire        module_pulled_event,
  input  wire        module_missing_event,
  input  wire        irq_ordinary,
  input  wire        irq_on_key,
  output reg         cpu_irq_ff
);

  localparam ST_IDLE = 1'b0;
  localparam ST_XFER = 1'b1;

  reg [63:0] wreg_ff [0:3];
  reg [63:0] scr_ff  [0:4];
  reg [19:0] dptr_ff [0:1];
  reg [19:0] imm_ff;
  reg [3:0]  p_ff;
  reg        carry_ff;
  reg        dec_ff;
  reg        int_en_ff;
  reg [11:0] flags_ff;
  reg [3:0]  hw_ff;
  reg        state_ff;
  reg [1:0]  mreg_ff;
  reg [3:0]  mcur_ff;
  reg [3:0]  mlast_ff;
  integer    k;

  // 16-nibble add or subtract across digits lo..hi
  function [64:0] nib_arith;
    input [63:0] x;
    input [63:0] y;
    input        sub;
    input        dec;
    input        cin;
    input [3:0]  lo;
    input [3:0]  hi;
    reg   [4:0]  t;
    reg          c;
    reg   [63:0] r;
    integer      i;
    begin
      r = x;
      c = cin;
      for (i = 0; i < 16; i = i + 1) begin
        if (i >= lo && i <= hi) begin
          if (!sub) begin
            t = {1'b0, x[4*i +: 4]} + {1'b0, y[4*i +: 4]} + {4'h0, c};
            if (dec && t > `DEC_MAX) begin
              t = t + `DEC_ADJ;
              c = 1'b1;
            end else begin
              c = t[4];
            end
          end else begin
            t = {1'b0, x[4*i +: 4]} - {1'b0, y[4*i +: 4]} - {4'h0, c};
            c = t[4];
            // a decimal borrow wraps to ten, not sixteen
            if (dec && c)
              t = t - `DEC_ADJ;
          end
          r[4*i +: 4] = t[3:0];
        end
      end
      nib_arith = {c, r};
    end
  endfunction

  // command decode
  wire [5:0] op   = avs_writedata[`CMD_OP];
  wire [3:0] fs   = avs_writedata[`CMD_FS];
  wire [1:0] ri   = avs_writedata[`CMD_R];
  wire [1:0] si   = avs_writedata[`CMD_S];
  wire [3:0] n    = avs_writedata[`CMD_N];
  wire       dsel = avs_writedata[`CMD_DP];
  wire       low4 = avs_writedata[`CMD_LOW4];
  wire       busy = (state_ff == ST_XFER);

  // refusing a command while a transfer runs holds waitrequest high
  wire bus_take = (avs_read | avs_write) & avs_waitrequest &
                  ~(avs_write & (avs_address == `OFS_CMD) & busy);
  wire exec     = bus_take & avs_write & (avs_address == `OFS_CMD);

  reg [3:0] lo;
  reg [3:0] hi;
  always @* begin
    case (fs)
      `FS_P:   begin lo = p_ff;  hi = p_ff;  end
      `FS_WP:  begin lo = 4'h0;  hi = p_ff;  end
      `FS_ESGN: begin lo = 4'h2;  hi = 4'h2;  end
      `FS_X:   begin lo = 4'h0;  hi = 4'h2;  end
      `FS_S:   begin lo = 4'hf;  hi = 4'hf;  end
      `FS_M:   begin lo = 4'h3;  hi = 4'he;  end
      `FS_B:   begin lo = 4'h0;  hi = 4'h1;  end
      `FS_A:   begin lo = 4'h0;  hi = 4'h4;  end
      default: begin lo = 4'h0;  hi = 4'hf;  end
    endcase
  end

  wire [63:0] fmask;
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : gen_mask
      assign fmask[4*g +: 4] = (g >= lo && g <= hi) ? 4'hf : 4'h0;
    end
  endgenerate

  wire [63:0] rr    = wreg_ff[ri];
  wire [63:0] ss    = wreg_ff[si];
  wire [63:0] cc    = wreg_ff[`REG_C];
  wire [63:0] rr_lo = rr >> {lo, 2'b00};
  wire [63:0] c_sh  = cc >> {n, 2'b00};
  wire [63:0] nmask = 64'hf << {n, 2'b00};
  wire [63:0] nines = dec_ff ? `DEC_NINES : 64'hffffffffffffffff;

  // mode steers every nibble of these
  wire [64:0] r_add  = nib_arith(rr, ss, 1'b0, dec_ff, 1'b0, lo, hi);
  wire [64:0] r_dbl  = nib_arith(rr, rr, 1'b0, dec_ff, 1'b0, lo, hi);
  wire [64:0] r_inc  = nib_arith(rr, 64'h0, 1'b0, dec_ff, 1'b1, lo, hi);
  wire [64:0] r_decr = nib_arith(rr, 64'h0, 1'b1, dec_ff, 1'b1, lo, hi);
  wire [64:0] r_rs   = nib_arith(rr, ss, 1'b1, dec_ff, 1'b0, lo, hi);
  wire [64:0] r_bk   = nib_arith(ss, rr, 1'b1, dec_ff, 1'b0, lo, hi);
  wire [64:0] r_neg  = nib_arith(64'h0, rr, 1'b1, dec_ff, 1'b0, lo, hi);
  wire [64:0] r_not  = nib_arith(nines, rr, 1'b1, dec_ff, 1'b0, lo, hi);

  wire sub_ok = ({ri, si} == {`REG_A, `REG_B}) | ({ri, si} == {`REG_B, `REG_C}) |
                ({ri, si} == {`REG_C, `REG_A}) | ({ri, si} == {`REG_D, `REG_C});

  wire [20:0] dp_sum  = {1'b0, dptr_ff[dsel]} + {16'h0, 1'b0, n} + 21'h1;
  wire [20:0] dp_diff = {1'b0, dptr_ff[dsel]} - {16'h0, 1'b0, n} - 21'h1;
  wire [20:0] cp_sum  = {1'b0, cc[19:0]} + {16'h0, 1'b0, p_ff} + 21'h1;

  reg sticky_set;
  always @* begin
    sticky_set = 1'b0;
    if (exec) begin
      case (op)
        `OP_SHR: sticky_set = (rr_lo[3:0] != 4'h0);
        `OP_SRC: sticky_set = (rr[3:0] != 4'h0);
        `OP_SRB: sticky_set = rr[0];
        default: sticky_set = 1'b0;
      endcase
    end
  end

  // single or full clear of hardware flags
  reg [3:0] hw_clr;
  always @* begin
    hw_clr = 4'h0;
    if (exec && op == `OP_HW_CLRALL)
      hw_clr = 4'hf;
    else if (exec && op == `OP_HW_CLR && n < 4'h4)
      hw_clr = 4'h1 << n[1:0];
  end
  wire [3:0] hw_set = {module_missing_event, module_pulled_event, sreq_event, sticky_set};

  // read mux
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0;
    if (avs_address == `OFS_STAT) begin
      rd_mux[`ST_P]     = p_ff;
      rd_mux[`ST_CARRY] = carry_ff;
      rd_mux[`ST_DEC]   = dec_ff;
      rd_mux[`ST_HW]    = hw_ff;
      rd_mux[`ST_INTEN] = int_en_ff;
      rd_mux[`ST_BUSY]  = busy;
      rd_mux[`ST_FLAGS] = flags_ff;
    end else if (avs_address == `OFS_IMM)
      rd_mux = {12'h0, imm_ff};
    else if (avs_address == `OFS_KEY)
      rd_mux = {keyscan_in, 4'h0, keyscan_out_ff};
    else if (avs_address == `OFS_DPTR0)
      rd_mux = {12'h0, dptr_ff[0]};
    else if (avs_address == `OFS_DPTR1)
      rd_mux = {12'h0, dptr_ff[1]};
    else if (avs_address[6:5] == `OFS_WREG)
      rd_mux = avs_address[2] ? wreg_ff[avs_address[4:3]][63:32]
                              : wreg_ff[avs_address[4:3]][31:0];
    else if (avs_address[6] == `OFS_SCR && avs_address[5:3] < `SCR_COUNT)
      rd_mux = avs_address[2] ? scr_ff[avs_address[5:3]][63:32]
                              : scr_ff[avs_address[5:3]][31:0];
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      for (k = 0; k < 4; k = k + 1)
        wreg_ff[k] <= 64'h0;
      for (k = 0; k < 5; k = k + 1)
        scr_ff[k] <= 64'h0;
      dptr_ff[0]      <= 20'h0;
      dptr_ff[1]      <= 20'h0;
      imm_ff          <= 20'h0;
      p_ff            <= 4'h0;
      carry_ff        <= 1'b0;
      dec_ff          <= 1'b0;
      int_en_ff       <= 1'b0;
      flags_ff        <= 12'h0;
      hw_ff           <= 4'h0;
      state_ff        <= ST_IDLE;
      mreg_ff         <= 2'h0;
      mcur_ff         <= 4'h0;
      mlast_ff        <= 4'h0;
      avs_readdata    <= 32'h0;
      avs_waitrequest <= 1'b1;
      mem_req_ff      <= 1'b0;
      mem_we_ff       <= 1'b0;
      mem_addr_ff     <= 20'h0;
      mem_wdata_ff    <= 4'h0;
      keyscan_out_ff  <= 12'h0;
      cpu_irq_ff      <= 1'b0;
    end else if (clk_en) begin
      avs_waitrequest <= 1'b1;
      // on-key and pulled module bypass the mask
      cpu_irq_ff <= irq_on_key | module_pulled_event | (irq_ordinary & int_en_ff);
      // set beats a clear in the same cycle
      hw_ff <= (hw_ff & ~hw_clr) | hw_set;
      if (bus_take) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= avs_read ? rd_mux : 32'h0;
        if (avs_write && avs_address == `OFS_IMM)
          imm_ff <= avs_writedata[19:0];
      end
      if (exec) begin
        case (op)
          `OP_P_SET: p_ff <= n;
          `OP_P_INC: begin
            p_ff     <= p_ff + 4'h1;
            carry_ff <= (p_ff == 4'hf);
          end
          `OP_P_DEC: begin
            p_ff     <= p_ff - 4'h1;
            carry_ff <= (p_ff == 4'h0);
          end
          // pointer plus one into C address field
          `OP_C_ADD_P1: begin
            wreg_ff[`REG_C][19:0] <= cp_sum[19:0];
            carry_ff              <= cp_sum[20];
          end
          // pointer and nibble n of C
          `OP_P_SWAP: begin
            p_ff            <= c_sh[3:0];
            wreg_ff[`REG_C] <= (cc & ~nmask) | ({60'h0, p_ff} << {n, 2'b00});
          end
          `OP_P_FROM_C: p_ff <= c_sh[3:0];
          `OP_P_TO_C: wreg_ff[`REG_C] <= (cc & ~nmask) | ({60'h0, p_ff} << {n, 2'b00});
          `OP_ST_SET: if (n < 4'hc) flags_ff <= flags_ff | (12'h1 << n);
          `OP_ST_CLR: if (n < 4'hc) flags_ff <= flags_ff & ~(12'h1 << n);
          `OP_ST_SWAP_X: begin
            flags_ff              <= cc[11:0];
            wreg_ff[`REG_C][11:0] <= flags_ff;
          end
          `OP_ST_TO_X: wreg_ff[`REG_C][11:0] <= flags_ff;
          `OP_X_TO_ST: flags_ff <= cc[11:0];
          `OP_ST_CLRALL: flags_ff <= 12'h0;
          `OP_MODE_HEX: dec_ff <= 1'b0;
          `OP_MODE_DEC: dec_ff <= 1'b1;
          `OP_INT_OFF: int_en_ff <= 1'b0;
          `OP_INT_ON:  int_en_ff <= 1'b1;
          `OP_OUT_X:    keyscan_out_ff <= cc[11:0];
          `OP_OUT_NIB0: keyscan_out_ff <= {8'h0, cc[3:0]};
          `OP_IN_TO_R: wreg_ff[ri][15:0] <= keyscan_in;
          `OP_SCR_SWAP: if (n < {1'b0, `SCR_COUNT}) begin
            scr_ff[n[2:0]] <= rr;
            wreg_ff[ri]    <= scr_ff[n[2:0]];
          end
          `OP_SCR_TO_R: if (n < {1'b0, `SCR_COUNT}) wreg_ff[ri] <= scr_ff[n[2:0]];
          `OP_R_TO_SCR: if (n < {1'b0, `SCR_COUNT}) scr_ff[n[2:0]] <= rr;
          // pointer swap and load, full or low four nibbles
          `OP_DP_SWAP: if (low4) begin
            dptr_ff[dsel][15:0] <= rr[15:0];
            wreg_ff[ri][15:0]   <= dptr_ff[dsel][15:0];
          end else begin
            dptr_ff[dsel]     <= rr[19:0];
            wreg_ff[ri][19:0] <= dptr_ff[dsel];
          end
          `OP_DP_LOAD: if (low4)
            dptr_ff[dsel][15:0] <= rr[15:0];
          else
            dptr_ff[dsel] <= rr[19:0];
          `OP_DP_ADD: begin
            dptr_ff[dsel] <= dp_sum[19:0];
            carry_ff      <= dp_sum[20];
          end
          `OP_DP_SUB: begin
            dptr_ff[dsel] <= dp_diff[19:0];
            carry_ff      <= dp_diff[20];
          end
          `OP_DP_IMM: begin
            if (n == `IMM_W2)
              dptr_ff[dsel][7:0] <= imm_ff[7:0];
            else if (n == `IMM_W4)
              dptr_ff[dsel][15:0] <= imm_ff[15:0];
            else if (n == `IMM_W5)
              dptr_ff[dsel] <= imm_ff;
          end
          // start nibble-serial transfer at pointer address
          `OP_MEM_RD, `OP_MEM_WR: begin
            state_ff     <= ST_XFER;
            mreg_ff      <= ri;
            mcur_ff      <= lo;
            mlast_ff     <= hi;
            mem_req_ff   <= 1'b1;
            mem_we_ff    <= (op == `OP_MEM_WR);
            mem_addr_ff  <= dptr_ff[dsel];
            mem_wdata_ff <= rr_lo[3:0];
          end
          `OP_SHL: wreg_ff[ri] <= (rr & ~fmask) | (((rr & fmask) << 4) & fmask);
          `OP_SHR: wreg_ff[ri] <= (rr & ~fmask) | (((rr & fmask) >> 4) & fmask);
          `OP_SLC: wreg_ff[ri] <= {rr[59:0], rr[63:60]};
          `OP_SRC: wreg_ff[ri] <= {rr[3:0], rr[63:4]};
          `OP_SRB: wreg_ff[ri] <= {1'b0, rr[63:1]};
          `OP_AND: wreg_ff[ri] <= (rr & ~fmask) | (rr & ss & fmask);
          `OP_OR:  wreg_ff[ri] <= (rr & ~fmask) | ((rr | ss) & fmask);
          `OP_NEG: begin
            wreg_ff[ri] <= r_neg[63:0];
            carry_ff    <= r_neg[64];
          end
          `OP_NOT: begin
            wreg_ff[ri] <= r_not[63:0];
            carry_ff    <= 1'b0;
          end
          `OP_ZERO: wreg_ff[ri] <= rr & ~fmask;
          `OP_DBL: begin
            wreg_ff[ri] <= r_dbl[63:0];
            carry_ff    <= r_dbl[64];
          end
          `OP_INC: begin
            wreg_ff[ri] <= r_inc[63:0];
            carry_ff    <= r_inc[64];
          end
          `OP_DEC: begin
            wreg_ff[ri] <= r_decr[63:0];
            carry_ff    <= r_decr[64];
          end
          `OP_ADD_R: begin
            wreg_ff[ri] <= r_add[63:0];
            carry_ff    <= r_add[64];
          end
          `OP_ADD_S: begin
            wreg_ff[si] <= r_add[63:0];
            carry_ff    <= r_add[64];
          end
          `OP_COPY_R: wreg_ff[ri] <= (rr & ~fmask) | (ss & fmask);
          `OP_COPY_S: wreg_ff[si] <= (ss & ~fmask) | (rr & fmask);
          `OP_SWAP: if (ri != si) begin
            wreg_ff[ri] <= (rr & ~fmask) | (ss & fmask);
            wreg_ff[si] <= (ss & ~fmask) | (rr & fmask);
          end
          `OP_SUB_RS: if (sub_ok) begin
            wreg_ff[ri] <= r_rs[63:0];
            carry_ff    <= r_rs[64];
          end
          `OP_RSUB_R: if (sub_ok) begin
            wreg_ff[ri] <= (rr & ~fmask) | (r_bk[63:0] & fmask);
            carry_ff    <= r_bk[64];
          end
          `OP_RSUB_S: if (sub_ok) begin
            wreg_ff[si] <= (ss & ~fmask) | (r_bk[63:0] & fmask);
            carry_ff    <= r_bk[64];
          end
          default: ;
        endcase
      end
      // one nibble per ack, field digits only
      case (state_ff)
        ST_XFER: if (mem_ack) begin
          if (!mem_we_ff)
            wreg_ff[mreg_ff] <= (wreg_ff[mreg_ff] & ~(64'hf << {mcur_ff, 2'b00})) |
                                ({60'h0, mem_rdata} << {mcur_ff, 2'b00});
          if (mcur_ff == mlast_ff) begin
            state_ff   <= ST_IDLE;
            mem_req_ff <= 1'b0;
            mem_we_ff  <= 1'b0;
          end else begin
            mcur_ff      <= mcur_ff + 4'h1;
            mem_addr_ff  <= mem_addr_ff + 20'h1;
            mem_wdata_ff <= wreg_ff[mreg_ff][{mcur_ff + 4'h1, 2'b00} +: 4];
          end
        end
        default: ;
      endcase
    end
  end

endmodule

// [nibble_cpu_datapath_chk.sv]
/* Port checker of the nibble datapath: bus takes, memory transfers, irqs.
   Assumes binding onto the datapath, one clock, clk_en held high. */
`timescale 1ns/1ns
`include "nibble_cpu_defs.vh"
module nibble_cpu_datapath_chk (
  // clock and reset
  input wire        ref_clk,
  input wire        sys_rst,
  // register bus
  input wire [6:0]  avs_address,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire        avs_waitrequest,
  // memory port
  input wire        mem_req_ff,
  input wire        mem_we_ff,
  input wire [19:0] mem_addr_ff,
  input wire        mem_ack,
  // keyscan and interrupts
  input wire [11:0] keyscan_out_ff,
  input wire        irq_ordinary,
  input wire        irq_on_key,
  input wire        module_pulled_event,
  input wire        cpu_irq_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // a command word is taken only while no transfer runs
  wire       cmd_take = avs_write && avs_address == `OFS_CMD && avs_waitrequest && !mem_req_ff;
  wire [5:0] op       = avs_writedata[`CMD_OP];
  sequence s_go(we); mem_req_ff && mem_we_ff == we; endsequence
  sequence s_step; mem_req_ff && mem_ack ##1 mem_req_ff; endsequence
  a_mem_write_go: assert property (
    cmd_take && op == `OP_MEM_WR |=> s_go(1'b1)) else $error("write transfer not started");
  a_mem_read_go: assert property (
    cmd_take && op == `OP_MEM_RD |=> s_go(1'b0)) else $error("read transfer not started");
  a_mem_hold: assert property (
    mem_req_ff && !mem_ack |=> mem_req_ff && $stable(mem_addr_ff) && $stable(mem_we_ff))
    else $error("memory request moved before ack");
  a_addr_step: assert property (
    s_step |-> mem_addr_ff == $past(mem_addr_ff) + 20'h1) else $error("nibble address skipped");
  a_irq_key: assert property (
    irq_on_key |=> cpu_irq_ff) else $error("key interrupt masked");
  a_irq_pulled: assert property (
    module_pulled_event |=> cpu_irq_ff) else $error("pulled interrupt masked");
  a_irq_quiet: assert property (
    !irq_on_key && !module_pulled_event && !irq_ordinary |=> !cpu_irq_ff)
    else $error("interrupt without cause");
  a_out_quiet: assert property (
    !cmd_take |=> $stable(keyscan_out_ff)) else $error("keyscan output changed unbidden");
  a_nop_quiet: assert property (
    cmd_take && op == `OP_NOP |=> !mem_req_ff && $stable(keyscan_out_ff))
    else $error("idle command had an effect");
endmodule
bind nibble_cpu_datapath nibble_cpu_datapath_chk chk_inst (.ref_clk, .sys_rst, .avs_address,
  .avs_write, .avs_writedata, .avs_waitrequest, .mem_req_ff, .mem_we_ff, .mem_addr_ff,
  .mem_ack, .keyscan_out_ff, .irq_ordinary, .irq_on_key, .module_pulled_event, .cpu_irq_ff);

// [nibble_cpu_datapath_tb_top.sv]
/* Command-sequence testbench of the nibble datapath over Avalon.
   Assumes the memory model and the bound checker. */
`timescale 1ns/1ns
`include "nibble_cpu_defs.vh"
module nibble_cpu_datapath_tb_top;
  reg         ref_clk, avs_read, avs_write, irq_ordinary, irq_on_key, pulled;
  reg         sys_rst = 1'b1;
  reg  [6:0]  avs_address;
  reg  [31:0] avs_writedata, rv;
  reg  [15:0] keyscan_in = 16'h0999;
  reg  [1:0]  lag = 2'h2;
  wire [31:0] avs_readdata;
  wire [19:0] mem_addr_ff;
  wire [11:0] keyscan_out_ff;
  wire [3:0]  mem_wdata_ff, mem_rdata;
  wire        avs_waitrequest, mem_req_ff, mem_we_ff, mem_ack, cpu_irq_ff;
  integer     fails = 0;
  integer     check_count = 0;
  nibble_cpu_datapath nibble_cpu_datapath_inst (.ref_clk, .sys_rst, .clk_en(1'b1),
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .mem_req_ff, .mem_we_ff, .mem_addr_ff, .mem_wdata_ff, .mem_rdata, .mem_ack, .keyscan_in,
    .keyscan_out_ff, .sreq_event(pulled), .module_pulled_event(pulled),
    .module_missing_event(pulled), .irq_ordinary, .irq_on_key, .cpu_irq_ff);
  nibble_mem_model nibble_mem_model_inst (.ref_clk, .lag, .mem_req_ff, .mem_we_ff,
    .mem_addr_ff, .mem_wdata_ff, .mem_rdata, .mem_ack);
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // one idle edge after release keeps strobes from toggling twice in a step
  task bus(input rd, input [6:0] a, input [31:0] d);
    integer k;
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= !rd;
      k = 0;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0 && k < 300) begin
        @(posedge ref_clk);
        k = k + 1;
      end
      if (k == 300) fails = fails + 1;
      rv = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task cm(input [5:0] op, input [1:0] r, input [3:0] n, input [3:0] fs, input dp);
    bus(1'b0, `OFS_CMD, {13'h0, dp, n, 2'h0, r, fs, op});
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    fails = fails + 1;
    wrap_up;
  end
  initial begin
    {avs_read, avs_write, irq_ordinary, irq_on_key, pulled} = 5'h0;
    avs_address = 7'h0;
    avs_writedata = 32'h0;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    bus(1'b1, `OFS_STAT, 0);
    chk(rv, 32'h0);
    cm(`OP_P_SET, 0, 15, 0, 0);
    cm(`OP_P_INC, 0, 0, 0, 0);
    bus(1'b1, `OFS_STAT, 0);
    chk(rv & 32'h1f, 32'h10);
    cm(`OP_P_DEC, 0, 0, 0, 0);
    bus(1'b1, `OFS_STAT, 0);
    chk(rv & 32'h1f, 32'h1f);
    bus(1'b0, `OFS_IMM, 32'h12345);
    cm(`OP_DP_IMM, 0, 5, 0, 0);
    bus(1'b0, `OFS_IMM, 32'habcde);
    cm(`OP_DP_IMM, 0, 2, 0, 0);
    cm(`OP_DP_ADD, 0, 15, 0, 0);
    bus(1'b1, `OFS_DPTR0, 0);
    chk(rv, 32'h123ee);
    cm(`OP_DP_IMM, 0, 4, 0, 1);
    cm(`OP_DP_SUB, 0, 0, 0, 1);
    bus(1'b1, `OFS_DPTR1, 0);
    chk(rv, 32'hbcdd);
    cm(`OP_DP_SWAP, `REG_A, 0, 0, 0);
    bus(1'b1, `OFS_DPTR0, 0);
    chk(rv, 32'h0);
    cm(`OP_MEM_WR, `REG_A, 0, `FS_A, 1);
    lag <= 2'h0;
    cm(`OP_MEM_RD, `REG_C, 0, `FS_B, 1);
    cm(`OP_NOP, 0, 0, 0, 0);
    bus(1'b1, 7'h30, 0);
    chk(rv, 32'hee);
    cm(`OP_MEM_RD, `REG_C, 0, `FS_A, 1);
    cm(`OP_SRB, `REG_C, 0, 0, 0);
    bus(1'b1, 7'h30, 0);
    chk(rv, 32'h91f7);
    bus(1'b1, `OFS_STAT, 0);
    chk(rv & 32'h40, 32'h0);
    cm(`OP_SRB, `REG_C, 0, 0, 0);
    bus(1'b1, `OFS_STAT, 0);
    chk(rv & 32'h40, 32'h40);
    cm(`OP_HW_CLR, 0, 0, 0, 0);
    cm(`OP_NEG, `REG_C, 0, `FS_W, 0);
    bus(1'b1, `OFS_STAT, 0);
    chk(rv & 32'h50, 32'h10);
    bus(1'b1, 7'h30, 0);
    chk(rv, 32'hffffb705);
    cm(`OP_NOT, `REG_C, 0, `FS_W, 0);
    bus(1'b1, `OFS_STAT, 0);
    chk(rv & 32'h10, 32'h0);
    cm(`OP_ST_SET, 0, 11, 0, 0);
    cm(`OP_ST_SET, 0, 0, 0, 0);
    cm(`OP_ST_TO_X, 0, 0, 0, 0);
    cm(`OP_OUT_X, 0, 0, 0, 0);
    chk(keyscan_out_ff, 32'h801);
    cm(`OP_R_TO_SCR, `REG_C, 4, 0, 0);
    bus(1'b1, 7'h60, 0);
    chk(rv, 32'h4801);
    cm(`OP_P_SWAP, 0, 1, 0, 0);
    cm(`OP_C_ADD_P1, 0, 0, 0, 0);
    cm(`OP_SUB_RS, `REG_C, 0, `FS_W, 0);
    bus(1'b1, 7'h30, 0);
    chk(rv, 32'hffff2504);
    cm(`OP_IN_TO_R, `REG_A, 0, 0, 0);
    cm(`OP_MODE_DEC, 0, 0, 0, 0);
    cm(`OP_INC, `REG_A, 0, `FS_X, 0);
    bus(1'b1, 7'h20, 0);
    chk(rv & 32'hffff, 32'h0);
    bus(1'b1, `OFS_STAT, 0);
    chk(rv & 32'h30, 32'h30);
    irq_ordinary <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(cpu_irq_ff, 32'h0);
    cm(`OP_INT_ON, 0, 0, 0, 0);
    chk(cpu_irq_ff, 32'h1);
    irq_ordinary <= 1'b0;
    cm(`OP_INT_OFF, 0, 0, 0, 0);
    irq_on_key <= 1'b1;
    pulled <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(cpu_irq_ff, 32'h1);
    irq_on_key <= 1'b0;
    pulled <= 1'b0;
    bus(1'b1, `OFS_STAT, 0);
    chk(rv & 32'h3c0, 32'h380);
    cm(`OP_HW_CLRALL, 0, 0, 0, 0);
    bus(1'b1, `OFS_STAT, 0);
    chk(rv & 32'h3c0, 32'h0);
    wrap_up;
  end
endmodule

// [nibble_cpu_defs.vh]
/*
  Constants of the nibble CPU datapath: Avalon register offsets, command
  word fields, operation codes, field-select codes and flag positions.
  Assumes it is included by its bare name from the datapath module.
*/
`ifndef NIBBLE_CPU_DEFS_VH
`define NIBBLE_CPU_DEFS_VH

// register byte offsets
`define OFS_STAT   7'h00
`define OFS_IMM    7'h04
`define OFS_CMD    7'h08
`define OFS_KEY    7'h0c
`define OFS_DPTR0  7'h10
`define OFS_DPTR1  7'h14
`define OFS_WREG   2'b01
`define OFS_SCR    1'b1
`define SCR_COUNT  3'h5

// command word fields
`define CMD_OP     5:0
`define CMD_FS     9:6
`define CMD_R      11:10
`define CMD_S      13:12
`define CMD_N      17:14
`define CMD_DP     18
`define CMD_LOW4   19

// status word fields
`define ST_P       3:0
`define ST_CARRY   4
`define ST_DEC     5
`define ST_HW      9:6
`define ST_INTEN   10
`define ST_BUSY    11
`define ST_FLAGS   23:12

// hardware flag bits
`define HW_STICKY  0
`define HW_SREQ    1
`define HW_PULLED  2
`define HW_MISSING 3

// working register indices
`define REG_A      2'h0
`define REG_B      2'h1
`define REG_C      2'h2
`define REG_D      2'h3

// field selects
`define FS_P       4'h0
`define FS_WP      4'h1
`define FS_ESGN    4'h2
`define FS_X       4'h3
`define FS_S       4'h4
`define FS_M       4'h5
`define FS_B       4'h6
`define FS_W       4'h7
`define FS_A       4'h8

// decimal digit limits
`define DEC_MAX    5'h09
`define DEC_ADJ    5'h06
`define DEC_NINES  64'h9999999999999999

// operation codes
`define OP_NOP       6'h00
`define OP_P_SET     6'h01
`define OP_P_INC     6'h02
`define OP_P_DEC     6'h03
`define OP_C_ADD_P1  6'h04
`define OP_P_SWAP    6'h05
`define OP_P_FROM_C  6'h06
`define OP_P_TO_C    6'h07
`define OP_ST_SET    6'h08
`define OP_ST_CLR    6'h09
`define OP_ST_SWAP_X 6'h0a
`define OP_ST_TO_X   6'h0b
`define OP_X_TO_ST   6'h0c
`define OP_ST_CLRALL 6'h0d
`define OP_HW_CLR    6'h0e
`define OP_HW_CLRALL 6'h0f
`define OP_MODE_HEX  6'h10
`define OP_MODE_DEC  6'h11
`define OP_INT_OFF   6'h12
`define OP_INT_ON    6'h13
`define OP_OUT_X     6'h14
`define OP_OUT_NIB0  6'h15
`define OP_IN_TO_R   6'h16
`define OP_SCR_SWAP  6'h17
`define OP_SCR_TO_R  6'h18
`define OP_R_TO_SCR  6'h19
`define OP_DP_SWAP   6'h1a
`define OP_DP_LOAD   6'h1b
`define OP_DP_ADD    6'h1c
`define OP_DP_SUB    6'h1d
`define OP_DP_IMM    6'h1e
`define OP_MEM_RD    6'h1f
`define OP_MEM_WR    6'h20
`define OP_SHL       6'h21
`define OP_SHR       6'h22
`define OP_SLC       6'h23
`define OP_SRC       6'h24
`define OP_SRB       6'h25
`define OP_AND       6'h26
`define OP_OR        6'h27
`define OP_NEG       6'h28
`define OP_NOT       6'h29
`define OP_ZERO      6'h2a
`define OP_DBL       6'h2b
`define OP_INC       6'h2c
`define OP_DEC       6'h2d
`define OP_ADD_R     6'h2e
`define OP_ADD_S     6'h2f
`define OP_COPY_R    6'h30
`define OP_COPY_S    6'h31
`define OP_SWAP      6'h32
`define OP_SUB_RS    6'h33
`define OP_RSUB_R    6'h34
`define OP_RSUB_S    6'h35

// immediate widths for pointer loads, in nibbles
`define IMM_W2     4'h2
`define IMM_W4     4'h4
`define IMM_W5     4'h5

`endif

// [nibble_mem_model.sv]
/* Nibble memory on the system bus, acking after lag cycles.
   Assumes addresses fit 8 bits; rdata toggles when not acking. */
`timescale 1ns/1ns
module nibble_mem_model (
  // clock and pacing
  input  wire        ref_clk,
  input  wire [1:0]  lag,
  // memory port
  input  wire        mem_req_ff,
  input  wire        mem_we_ff,
  input  wire [19:0] mem_addr_ff,
  input  wire [3:0]  mem_wdata_ff,
  output reg  [3:0]  mem_rdata,
  output reg         mem_ack
);
  reg [3:0] store [0:255];
  reg [1:0] wait_cnt = 2'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 4'h5;
  // one nibble per ack at the shown address
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req_ff && !mem_ack) begin
      if (wait_cnt < lag) begin
        wait_cnt <= wait_cnt + 2'h1;
      end else begin
        wait_cnt <= 2'h0;
        mem_ack <= 1'b1;
        mem_rdata <= store[mem_addr_ff[7:0]];
        if (mem_we_ff) store[mem_addr_ff[7:0]] <= mem_wdata_ff;
      end
    end
  end
endmodule
